// File: fss_status_stats.sv
module fss_status_stats import fss_pkg::*; #(
  parameter int unsigned SLAVES = FSS_MAX_SLAVES,
  parameter logic [15:0] TICK_MULT = 16'h0001,
  parameter logic [15:0] TICK_DIV = 16'h0001
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire fss_poll_s poll,
  input wire logic cycle_start,
  input wire logic out_prep_done,
  input wire logic in_prep_start,
  input wire logic in_prep_done,
  input wire logic output_buffer_event,
  input wire logic distributed_sync_pulse,
  input wire logic [7:0] sync_mode,
  input wire logic sync_dist_enable,
  input wire logic [31:0] output_delay_ns_in,
  input wire fss_rd_req_s rd_req,
  output fss_rd_rsp_s rd_rsp,
  output logic [7:0] slave_status_count,
  output logic [7:0] cycle_stats_count
);

  // ---------------------------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [1:0] sm_sync_reg;
  logic [1:0] sy_sync_reg;
  logic sm_evt_reg;
  logic sy_evt_reg;
  logic sm_evt;
  logic sy_evt;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sm_sync_reg <= 2'b00;
      sy_sync_reg <= 2'b00;
      sm_evt_reg <= 1'b0;
      sy_evt_reg <= 1'b0;
    end else begin
      sm_sync_reg <= {sm_sync_reg[0], output_buffer_event};
      sy_sync_reg <= {sy_sync_reg[0], distributed_sync_pulse};
      sm_evt_reg <= sm_sync_reg[1];
      sy_evt_reg <= sy_sync_reg[1];
    end
  end
  assign sm_evt = sm_sync_reg[1] & ~sm_evt_reg;
  assign sy_evt = sy_sync_reg[1] & ~sy_evt_reg;

  // ---------------------------------------------------------------
  // Slave status code encoding
  // ---------------------------------------------------------------
  fss_code_e code;

  always_comb begin
    if (poll.deactivated) begin
      code = FSS_ST_DEACTIVATED;
    end else if (poll.no_response) begin
      code = FSS_ST_NO_RESPONSE;
    end else if (poll.bus_err) begin
      code = FSS_ST_BUS_ERR;
    end else if (poll.telegram_err) begin
      code = FSS_ST_TELEGRAM_ERR;
    end else if (poll.unexpected) begin
      code = FSS_ST_UNEXPECTED;
    end else if (poll.other_master) begin
      code = FSS_ST_OTHER_MASTER;
    end else if (poll.bad_response) begin
      code = FSS_ST_BAD_RESPONSE;
    end else if (poll.param_err) begin
      code = FSS_ST_PARAM_ERR;
    end else if (poll.unsupported) begin
      code = FSS_ST_UNSUPPORTED;
    end else if (poll.config_err) begin
      code = FSS_ST_CONFIG_ERR;
    end else if (poll.no_resources) begin
      code = FSS_ST_NO_RESOURCES;
    end else if (poll.not_activated) begin
      code = FSS_ST_NOT_ACTIVATED;
    end else if (poll.static_diag) begin
      code = FSS_ST_STATIC_DIAG;
    end else if (poll.starting) begin
      code = FSS_ST_STARTUP;
    end else if (!poll.host_data_on) begin
      code = FSS_ST_READY_NO_DATA;
    end else begin
      code = FSS_ST_EXCHANGE;
    end
  end

  // ---------------------------------------------------------------
  // Status memory with reset sweep
  // ---------------------------------------------------------------
  logic [6:0] init_reg;
  logic [6:0] init_next;
  logic init_busy_reg;
  logic init_busy_next;
  logic mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [6:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic poll_ok;

  assign poll_ok = poll.valid && (32'(poll.slave) < SLAVES);

  always_comb begin
    init_next = init_reg;
    init_busy_next = init_busy_reg;
    if (init_busy_reg) begin
      init_next = init_reg + 7'd1;
      if (32'(init_reg) == SLAVES - 1) begin
        init_busy_next = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_reg <= 7'd0;
      init_busy_reg <= 1'b1;
    end else begin
      init_reg <= init_next;
      init_busy_reg <= init_busy_next;
    end
  end

  // Each poll of a slave below SLAVES rewrites its slave's byte once the sweep, which seeds start-up codes, is done.
  assign mem_we = init_busy_reg || poll_ok;
  assign mem_waddr = init_busy_reg ? init_reg : poll.slave;
  assign mem_wdata = init_busy_reg ? FSS_CODE_RESET : 8'(code);
  assign mem_raddr = 7'(rd_req.sub - FSS_SUB_FIRST_SLAVE);

  fss_code_mem #(
    .DEPTH(SLAVES),
    .AW(7)
  ) u_mem (
    .sys_clk(sys_clk),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata)
  );

  // ---------------------------------------------------------------
  // Cycle measurements in ticks and ns
  // ---------------------------------------------------------------
  logic [15:0] cyc_cnt_reg, cyc_cnt_next;
  logic [15:0] sp_cnt_reg, sp_cnt_next;
  logic [15:0] in_cnt_reg, in_cnt_next;
  logic [31:0] dist_cnt_reg, dist_cnt_next;
  logic in_run_reg, in_run_next;
  logic dist_run_reg, dist_run_next;
  logic [15:0] out_prep_reg, out_prep_next;
  logic [15:0] in_prep_reg, in_prep_next;
  logic [15:0] spacing_cur_reg, spacing_cur_next;
  logic [31:0] dist_cur_reg, dist_cur_next;
  logic [7:0] tick_reg, tick_next;
  logic tick_en;
  logic [15:0] last_cycle_time, last_cycle_time_next;
  logic [15:0] event_spacing_time, event_spacing_time_next;
  logic [15:0] output_prep_time, output_prep_time_next;
  logic [15:0] input_prep_time, input_prep_time_next;
  logic [31:0] output_delay_ns, output_delay_ns_next;
  logic [31:0] sync_event_distance_ns, sync_event_distance_ns_next;
  logic spacing_on;

  // Local tick is a 100 ns enable pulse from the system clock divider.
  assign tick_en = (tick_reg == FSS_TICK_100NS_DIV - 8'd1);
  assign spacing_on = (sync_mode == FSS_SYNC_MODE_A) || (sync_mode == FSS_SYNC_MODE_B);

  always_comb begin
    tick_next = tick_en ? 8'd0 : tick_reg + 8'd1;
    cyc_cnt_next = cyc_cnt_reg + {15'd0, tick_en};
    sp_cnt_next = sp_cnt_reg + {15'd0, tick_en};
    in_cnt_next = in_cnt_reg + {15'd0, tick_en && in_run_reg};
    in_run_next = in_run_reg;
    out_prep_next = out_prep_reg;
    in_prep_next = in_prep_reg;
    spacing_cur_next = spacing_cur_reg;
    dist_cur_next = dist_cur_reg;
    dist_run_next = dist_run_reg;
    dist_cnt_next = dist_run_reg ? dist_cnt_reg + FSS_CLK_PERIOD_NS : dist_cnt_reg;
    last_cycle_time_next = last_cycle_time;
    event_spacing_time_next = event_spacing_time;
    output_prep_time_next = output_prep_time;
    input_prep_time_next = input_prep_time;
    output_delay_ns_next = output_delay_ns;
    sync_event_distance_ns_next = sync_event_distance_ns;
    if (out_prep_done) begin
      out_prep_next = cyc_cnt_reg;
    end
    if (in_prep_start) begin
      in_run_next = 1'b1;
      in_cnt_next = 16'd0;
    end
    if (in_prep_done) begin
      in_run_next = 1'b0;
      in_prep_next = in_cnt_reg;
    end
    if (sm_evt) begin
      sp_cnt_next = 16'd0;
      if (spacing_on) begin
        spacing_cur_next = sp_cnt_reg;
      end
      if (sync_dist_enable) begin
        dist_run_next = 1'b1;
        dist_cnt_next = 32'd0;
      end
    end
    if (sy_evt && dist_run_reg) begin
      dist_run_next = 1'b0;
      dist_cur_next = dist_cnt_reg;
    end
    // Published values change only at the cycle boundary.
    if (cycle_start) begin
      cyc_cnt_next = 16'd0;
      last_cycle_time_next = cyc_cnt_reg;
      output_prep_time_next = out_prep_reg;
      input_prep_time_next = in_prep_reg;
      event_spacing_time_next = spacing_cur_reg;
      output_delay_ns_next = output_delay_ns_in;
      if (sync_dist_enable) begin
        sync_event_distance_ns_next = dist_cur_reg;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_reg <= 8'd0;
      cyc_cnt_reg <= FSS_TIME16_RESET;
      sp_cnt_reg <= FSS_TIME16_RESET;
      in_cnt_reg <= FSS_TIME16_RESET;
      in_run_reg <= 1'b0;
      dist_run_reg <= 1'b0;
      dist_cnt_reg <= FSS_TIME32_RESET;
      out_prep_reg <= FSS_TIME16_RESET;
      in_prep_reg <= FSS_TIME16_RESET;
      spacing_cur_reg <= FSS_TIME16_RESET;
      dist_cur_reg <= FSS_TIME32_RESET;
      last_cycle_time <= FSS_TIME16_RESET;
      event_spacing_time <= FSS_TIME16_RESET;
      output_prep_time <= FSS_TIME16_RESET;
      input_prep_time <= FSS_TIME16_RESET;
      output_delay_ns <= FSS_TIME32_RESET;
      sync_event_distance_ns <= FSS_TIME32_RESET;
    end else begin
      tick_reg <= tick_next;
      cyc_cnt_reg <= cyc_cnt_next;
      sp_cnt_reg <= sp_cnt_next;
      in_cnt_reg <= in_cnt_next;
      in_run_reg <= in_run_next;
      dist_run_reg <= dist_run_next;
      dist_cnt_reg <= dist_cnt_next;
      out_prep_reg <= out_prep_next;
      in_prep_reg <= in_prep_next;
      spacing_cur_reg <= spacing_cur_next;
      dist_cur_reg <= dist_cur_next;
      last_cycle_time <= last_cycle_time_next;
      event_spacing_time <= event_spacing_time_next;
      output_prep_time <= output_prep_time_next;
      input_prep_time <= input_prep_time_next;
      output_delay_ns <= output_delay_ns_next;
      sync_event_distance_ns <= sync_event_distance_ns_next;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic pend_slave_reg, pend_slave_next;
  logic pend_stats_reg, pend_stats_next;
  logic [31:0] stats_word_reg, stats_word_next;
  fss_rd_rsp_s rd_rsp_next;
  logic slave_hit;

  assign slave_hit = (rd_req.sub >= FSS_SUB_FIRST_SLAVE) && (rd_req.sub <= FSS_SUB_LAST_SLAVE)
                     && (32'(rd_req.sub) <= SLAVES);

  always_comb begin
    pend_slave_next = rd_req.rd && !rd_req.stats;
    pend_stats_next = rd_req.rd && rd_req.stats;
    stats_word_next = 32'h00000000;
    if (rd_req.stats) begin
      case (rd_req.sub)
        8'h00: stats_word_next = {24'h000000, FSS_STATS_COUNT};
        FSS_SUB_MULT: stats_word_next = {16'h0000, TICK_MULT};
        FSS_SUB_DIV: stats_word_next = {16'h0000, TICK_DIV};
        FSS_SUB_CYCLE: stats_word_next = {16'h0000, last_cycle_time};
        FSS_SUB_SPACING: stats_word_next = {16'h0000, event_spacing_time};
        FSS_SUB_OUT_PREP: stats_word_next = {16'h0000, output_prep_time};
        FSS_SUB_IN_PREP: stats_word_next = {16'h0000, input_prep_time};
        FSS_SUB_OUT_DELAY: stats_word_next = output_delay_ns;
        FSS_SUB_SYNC_DIST: stats_word_next = sync_event_distance_ns;
        default: stats_word_next = 32'h00000000;
      endcase
    end else if (rd_req.sub == 8'h00) begin
      stats_word_next = SLAVES;
    end else if (slave_hit) begin
      stats_word_next = 32'h80000000;
    end
    rd_rsp_next.valid = pend_slave_reg || pend_stats_reg;
    rd_rsp_next.data = stats_word_reg;
    if (pend_slave_reg && stats_word_reg[31]) begin
      rd_rsp_next.data = {24'h000000, mem_rdata};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_slave_reg <= 1'b0;
      pend_stats_reg <= 1'b0;
      stats_word_reg <= 32'h00000000;
      rd_rsp <= '0;
      slave_status_count <= 8'h00;
      cycle_stats_count <= 8'h00;
    end else begin
      pend_slave_reg <= pend_slave_next;
      pend_stats_reg <= pend_stats_next;
      stats_word_reg <= stats_word_next;
      rd_rsp <= rd_rsp_next;
      slave_status_count <= 8'(SLAVES);
      cycle_stats_count <= FSS_STATS_COUNT;
    end
  end

endmodule

// File: fss_pkg.sv
// Functional notes
// - A slave that exchanges data with current inputs is reported as code 0.
// - Codes 1, 2 and 3 mean deactivated by the host, no response, and owned by another master.
// - Codes 4 to 7 mean bad response, parameter telegram error, unsupported function, config error.
// - Codes 8, 9 and 18 mean starting up, static diagnosis, and ready without host data.
// - Codes 11, 14 and 17 mean bus error, telegram error and unexpected telegram.
// - Codes 15 and 16 mean no resources and service not activated.
// - One read-only status byte per slave, subindex 1 to 125.
// - Cycle statistics shown are always those of the preceding cycle.
// - A 16-bit multiplier converts the four tick entries to 100 ns units.
// - A 16-bit divider is applied after multiplication to reach 100 ns units.
// - Cycle, output prep and input prep times are measured in ticks as 16-bit values.
// - The output event spacing is recorded only when the sync mode is 1 or 2.
// - The output delay time of the preceding cycle is reported as a 32-bit ns value.
// - The signed distance between output event and sync pulse is reported once enabled; the code counts unsigned ns from an output event to the next sync pulse.
// - The statistics header entry reports 8 subentries.
package fss_pkg;

  localparam int unsigned FSS_MAX_SLAVES = 125;
  localparam logic [7:0] FSS_STATS_COUNT = 8'h08;
  localparam logic [7:0] FSS_SUB_FIRST_SLAVE = 8'h01;
  localparam logic [7:0] FSS_SUB_LAST_SLAVE = 8'h7D;
  localparam logic [7:0] FSS_SUB_MULT = 8'h01;
  localparam logic [7:0] FSS_SUB_DIV = 8'h02;
  localparam logic [7:0] FSS_SUB_CYCLE = 8'h03;
  localparam logic [7:0] FSS_SUB_SPACING = 8'h04;
  localparam logic [7:0] FSS_SUB_OUT_PREP = 8'h05;
  localparam logic [7:0] FSS_SUB_IN_PREP = 8'h06;
  localparam logic [7:0] FSS_SUB_OUT_DELAY = 8'h07;
  localparam logic [7:0] FSS_SUB_SYNC_DIST = 8'h08;
  localparam logic [15:0] FSS_TIME16_RESET = 16'h0000;
  localparam logic [31:0] FSS_TIME32_RESET = 32'h00000000;
  localparam logic [7:0] FSS_CODE_RESET = 8'h08;
  localparam logic [7:0] FSS_SYNC_MODE_A = 8'h01;
  localparam logic [7:0] FSS_SYNC_MODE_B = 8'h02;
  localparam logic [7:0] FSS_TICK_100NS_DIV = 8'h04;
  localparam logic [31:0] FSS_CLK_PERIOD_NS = 32'h00000019;

  typedef enum logic [7:0] {
    FSS_ST_EXCHANGE = 8'h00,
    FSS_ST_DEACTIVATED = 8'h01,
    FSS_ST_NO_RESPONSE = 8'h02,
    FSS_ST_OTHER_MASTER = 8'h03,
    FSS_ST_BAD_RESPONSE = 8'h04,
    FSS_ST_PARAM_ERR = 8'h05,
    FSS_ST_UNSUPPORTED = 8'h06,
    FSS_ST_CONFIG_ERR = 8'h07,
    FSS_ST_STARTUP = 8'h08,
    FSS_ST_STATIC_DIAG = 8'h09,
    FSS_ST_BUS_ERR = 8'h0B,
    FSS_ST_TELEGRAM_ERR = 8'h0E,
    FSS_ST_NO_RESOURCES = 8'h0F,
    FSS_ST_NOT_ACTIVATED = 8'h10,
    FSS_ST_UNEXPECTED = 8'h11,
    FSS_ST_READY_NO_DATA = 8'h12
  } fss_code_e;

  // Outcome of one slave poll, reported by the bus engine.
  typedef struct packed {
    logic valid;
    logic [6:0] slave;
    logic deactivated;
    logic no_response;
    logic other_master;
    logic bad_response;
    logic param_err;
    logic unsupported;
    logic config_err;
    logic starting;
    logic static_diag;
    logic bus_err;
    logic telegram_err;
    logic no_resources;
    logic not_activated;
    logic unexpected;
    logic host_data_on;
  } fss_poll_s;

  // Register read request and answer.
  typedef struct packed {
    logic rd;
    logic stats;
    logic [7:0] sub;
  } fss_rd_req_s;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } fss_rd_rsp_s;

endpackage

// File: fss_code_mem.sv
module fss_code_mem import fss_pkg::*; #(
  parameter int unsigned DEPTH = FSS_MAX_SLAVES,
  parameter int unsigned AW = 7
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// File: fss_status_stats_properties.sv
module fss_status_stats_properties import fss_pkg::*; #(
  parameter int unsigned SLAVES = FSS_MAX_SLAVES,
  parameter logic [15:0] TICK_MULT = 16'h0001,
  parameter logic [15:0] TICK_DIV = 16'h0001
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire fss_rd_req_s rd_req,
  input wire fss_rd_rsp_s rd_rsp,
  input wire logic [7:0] slave_status_count,
  input wire logic [7:0] cycle_stats_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Cycles since reset release, so the fixed counts are judged only after sync.
  // ----
  logic [2:0] up_reg;
  logic [2:0] up_next;
  always_comb begin
    up_next = up_reg;
    if (up_reg != 3'h7) up_next = up_reg + 3'h1;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) up_reg <= 3'h0;
    else up_reg <= up_next;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_rd(logic st, logic [7:0] s);
    rd_req.rd && rd_req.stats == st && rd_req.sub == s;
  endsequence
  sequence s_ans(logic [31:0] v);
    ##2 rd_rsp.valid && rd_rsp.data == v;
  endsequence
  a_rsp_two_late: assert property (rd_req.rd |-> ##2 rd_rsp.valid)
    else $error("read answer missing");
  a_no_stray_rsp: assert property (rd_rsp.valid |-> $past(rd_req.rd, 2))
    else $error("answer without read");
  a_counts_fixed: assert property (up_reg > 3'h3 |->
    slave_status_count == 8'(SLAVES) && cycle_stats_count == FSS_STATS_COUNT)
    else $error("object counts wrong");
  a_head_eight: assert property (s_rd(1'b1, 8'h00) |-> s_ans(32'(FSS_STATS_COUNT)))
    else $error("stats header wrong");
  a_slave_head: assert property (s_rd(1'b0, 8'h00) |-> s_ans(32'(SLAVES)))
    else $error("slave header wrong");
  a_mult_value: assert property (s_rd(1'b1, FSS_SUB_MULT) |-> s_ans({16'h0, TICK_MULT}))
    else $error("multiplier wrong");
  a_div_value: assert property (s_rd(1'b1, FSS_SUB_DIV) |-> s_ans({16'h0, TICK_DIV}))
    else $error("divider wrong");
  a_code_in_set: assert property (rd_req.rd && !rd_req.stats &&
    rd_req.sub inside {[8'h01:8'h7D]} |->
    ##2 rd_rsp.data inside {[32'h0:32'h9], 32'hB, [32'hE:32'h12]})
    else $error("status code outside set");
  a_time_width: assert property (rd_req.rd && rd_req.stats &&
    rd_req.sub inside {[8'h01:8'h06]} |-> ##2 rd_rsp.data[31:16] == 16'h0)
    else $error("16-bit entry has upper bits");
  a_unmapped_zero: assert property (rd_req.rd && rd_req.stats &&
    rd_req.sub > FSS_SUB_SYNC_DIST |-> ##2 rd_rsp.data == 32'h0)
    else $error("unmapped entry not zero");
endmodule

// File: fss_slave_model.sv
module fss_slave_model import fss_pkg::*; (
  input wire logic sys_clk,
  output fss_poll_s poll
);
  timeunit 1ns;
  timeprecision 1ps;
  initial poll = '0;
  // Reports the outcome of one slave poll for exactly one cycle.
  task automatic send(input logic [6:0] slave, input logic [14:0] flags);
    poll = {1'b1, slave, flags};
    @(posedge sys_clk);
    #1;
    poll = '0;
  endtask
endmodule

// File: fieldbus_slave_status_cycle_stats_bench.sv
module fieldbus_slave_status_cycle_stats_bench import fss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] TMULT = 16'h0001;
  localparam logic [15:0] TDIV = 16'h0001;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  fss_poll_s poll;
  logic cycle_start = 1'b0;
  logic out_prep_done = 1'b0;
  logic in_prep_start = 1'b0;
  logic in_prep_done = 1'b0;
  logic output_buffer_event = 1'b0;
  logic distributed_sync_pulse = 1'b0;
  logic [7:0] sync_mode = 8'h00;
  logic sync_dist_enable = 1'b1;
  logic [31:0] output_delay_ns_in = 32'h0;
  fss_rd_req_s rd_req = '0;
  fss_rd_rsp_s rd_rsp;
  logic [7:0] slave_status_count;
  logic [7:0] cycle_stats_count;
  int num_errors = 0;
  int cmp_count = 0;
  logic [7:0] shadow [125];
  always #12.5 sys_clk = ~sys_clk;
  fss_status_stats #(.TICK_MULT(TMULT), .TICK_DIV(TDIV)) i_fss_status_stats (
    .sys_clk(sys_clk), .rst_b(rst_b), .poll(poll), .cycle_start(cycle_start),
    .out_prep_done(out_prep_done), .in_prep_start(in_prep_start),
    .in_prep_done(in_prep_done), .output_buffer_event(output_buffer_event),
    .distributed_sync_pulse(distributed_sync_pulse), .sync_mode(sync_mode),
    .sync_dist_enable(sync_dist_enable), .output_delay_ns_in(output_delay_ns_in),
    .rd_req(rd_req), .rd_rsp(rd_rsp), .slave_status_count(slave_status_count),
    .cycle_stats_count(cycle_stats_count)
  );
  fss_slave_model i_fss_slave_model (.sys_clk(sys_clk), .poll(poll));
  // ----
  // Shared tasks.
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic get(input logic st, input logic [7:0] sub, output logic [31:0] d);
    int n;
    n = 0;
    rd_req = {1'b1, st, sub};
    tick(1);
    rd_req = '0;
    while (rd_rsp.valid !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    if (n == 8) check(32'h0, 32'h1);
    d = rd_rsp.data;
  endtask
  function automatic logic [7:0] exp_code(input logic [14:0] f);
    int b [14] = '{14, 13, 5, 4, 1, 12, 11, 10, 9, 8, 3, 2, 6, 7};
    logic [7:0] c [14] = '{8'h01, 8'h02, 8'h0B, 8'h0E, 8'h11, 8'h03, 8'h04,
      8'h05, 8'h06, 8'h07, 8'h0F, 8'h10, 8'h09, 8'h08};
    for (int i = 0; i < 14; i++) if (f[b[i]]) return c[i];
    return f[0] ? 8'h00 : 8'h12;
  endfunction
  task automatic put(input logic [6:0] s, input logic [14:0] f);
    logic [31:0] d;
    i_fss_slave_model.send(s, f);
    if (s < 7'd125) shadow[s] = exp_code(f);
    tick(3);
    get(1'b0, 8'(s) + 8'h01, d);
    check(d, s < 7'd125 ? 32'(exp_code(f)) : 32'h0);
  endtask
  // Converts a tick entry to 100 ns units and allows one tick of phase slack.
  task automatic near(input logic [7:0] sub, input int clocks);
    logic [31:0] d;
    logic [47:0] v;
    logic [47:0] e;
    get(1'b1, sub, d);
    v = d * TMULT / TDIV;
    e = 48'(clocks / 4);
    check(32'(v + 1 >= e && v <= e + 1), 32'h1);
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----
  // Scenarios.
  // ----
  initial begin
    logic [31:0] d;
    logic [31:0] rv [10];
    logic [7:0] modes [4];
    void'($urandom(76448));
    foreach (shadow[i]) shadow[i] = FSS_CODE_RESET;
    rv = '{32'(FSS_STATS_COUNT), 32'(TMULT), 32'(TDIV), 0, 0, 0, 0, 0, 0, 0};
    modes = '{8'h00, 8'h03, 8'h01, 8'h02};
    tick(20);
    rst_b = 1'b1;
    tick(130);
    for (int i = 0; i < 10; i++) begin
      get(1'b1, 8'(i), d);
      check(d, rv[i]);
    end
    get(1'b0, 8'h00, d);
    check(d, 32'd125);
    check(32'(slave_status_count), 32'd125);
    check(32'(cycle_stats_count), 32'(FSS_STATS_COUNT));
    get(1'b0, FSS_SUB_LAST_SLAVE, d);
    check(d, 32'(FSS_CODE_RESET));
    put(7'd15, 15'h0000);
    for (int i = 0; i < 15; i++) put(7'(i), 15'(1) << i);
    put(7'd124, 15'h0001);
    put(7'd125, 15'h0002);
    repeat (40) put(7'($urandom_range(124)), 15'($urandom & $urandom & $urandom));
    for (int i = 0; i < 125; i++) begin
      get(1'b0, 8'(i + 1), d);
      check(d, 32'(shadow[i]));
    end
    foreach (modes[k]) begin
      sync_mode = modes[k];
      sync_dist_enable = k > 0;
      output_delay_ns_in = $urandom;
      cycle_start = 1'b1;
      tick(1);
      cycle_start = 1'b0;
      tick(19);
      out_prep_done = 1'b1;
      tick(1);
      out_prep_done = 1'b0;
      tick(19);
      in_prep_start = 1'b1;
      tick(1);
      in_prep_start = 1'b0;
      tick(39);
      in_prep_done = 1'b1;
      tick(1);
      in_prep_done = 1'b0;
      output_buffer_event = 1'b1;
      tick(10);
      output_buffer_event = 1'b0;
      tick(190);
      output_buffer_event = 1'b1;
      tick(40);
      distributed_sync_pulse = 1'b1;
      tick(10);
      output_buffer_event = 1'b0;
      distributed_sync_pulse = 1'b0;
      tick(69);
      cycle_start = 1'b1;
      tick(1);
      cycle_start = 1'b0;
      tick(4);
      near(FSS_SUB_CYCLE, 400);
      near(FSS_SUB_OUT_PREP, 20);
      near(FSS_SUB_IN_PREP, 40);
      near(FSS_SUB_SPACING, modes[k] inside {8'h01, 8'h02} ? 200 : 0);
      get(1'b1, FSS_SUB_OUT_DELAY, d);
      check(d, output_delay_ns_in);
      get(1'b1, FSS_SUB_SYNC_DIST, d);
      check(32'(d >= 32'd950 && d <= 32'd1050), 32'(k > 0));
    end
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end
endmodule
bind fss_status_stats fss_status_stats_properties #(
  .SLAVES(SLAVES), .TICK_MULT(TICK_MULT), .TICK_DIV(TICK_DIV)
) i_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .rd_req(rd_req), .rd_rsp(rd_rsp),
  .slave_status_count(slave_status_count), .cycle_stats_count(cycle_stats_count)
);
